/* File: pd_rx_interrupt_status.sv */
// Receive event and error interrupt status registers with Avalon-MM slave access.
//
// Notes on behaviour
// - Hardware sets status bits; software writes one to clear.
// - Interrupt only for enabled bits; status always records.
// - Bit 7 mirrors receive FIFO not empty, read-only.
// - Bus idle bit sets on idle; resets to one.
// - Idle bit is an event: on enable or idle.
// - Idle detection only while clocks run.
// - End bit on valid end framing; bad drops.
// - End bit only for accepted start types.
// - Start bit on valid start of enabled type.
// - Message done bit on successful reception.
// - Auto retry drops expected GoodCRC, no done.
// - Auto response drops duplicates, no done.
// - Done set before GoodCRC reply, regardless of success.
// - Limit bit when either counter reaches a nonzero limit.
// - Limit bit is level driven; clear counter first.
// - Corrupt packet sets bit 3 and cause flag.
// - No buffer sets overrun, FIFO-full flag, drop.
// - Protocol error on unexpected message awaiting GoodCRC.
// - Protocol error stores message and sets done.
// - Protocol error aborts retry, sets transmit aborted.
// - Discard bit on duplicate or expected GoodCRC drop.
`timescale 1ns/100ps

module pd_rx_interrupt_status (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic [pd_rx_irq_pkg::ADDR_W-1:0]  address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [31:0]                       writedata,
  input  wire logic [3:0]                        byteenable,
  output logic [31:0]                            readdata,
  output logic                                   waitrequest,
  input  wire pd_rx_irq_pkg::rx_in_t             rxIn,
  output pd_rx_irq_pkg::rx_out_t                 rxOut,
  output logic                                   irq
);
  import pd_rx_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and bus state.

  logic [7:0] eventStatus;
  logic [7:0] errorStatus;
  logic [7:0] eventEnable;
  logic [7:0] errorEnable;
  logic [4:0] frameAccept;
  logic [1:0] modeControl;
  logic [7:0] packetFlags;
  logic [7:0] badCrcCount;
  logic [7:0] dupCount;
  logic [7:0] countLimit;
  logic       busAck;
  logic       frameOpen;
  logic       idleSeen;
  logic       idleEnSeen;

  // Returns true when the byte address selects the given register index.
  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    hits = (addr == {idx, 2'b00});
  endfunction

  // Saturating increment used by both debug counters.
  function automatic logic [7:0] bump(input logic [7:0] value);
    bump = (value == 8'hFF) ? value : value + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake: every access waits one cycle, then completes.

  logic busWrite;
  logic lowLane;
  logic [7:0] wByte;

  assign waitrequest = (read | write) & ~busAck;
  assign busWrite    = write & busAck & byteenable[0];
  assign lowLane     = byteenable[0];
  assign wByte       = writedata[7:0];

  // Acknowledge pulses in the cycle after a request first appears.
  always_ff @(posedge mclk) begin
    if (rst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (read | write) & ~busAck;
    end
  end

  // Read data is loaded at the edge before the acknowledge cycle; unmapped reads return zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~busAck) begin
      readdata <= 32'h0000_0000;
      if (lowLane) begin
        if (hits(address, IDX_EVENT_STATUS)) readdata[7:0] <= eventStatus;
        if (hits(address, IDX_ERROR_STATUS)) readdata[7:0] <= errorStatus;
        if (hits(address, IDX_EVENT_ENABLE)) readdata[7:0] <= eventEnable;
        if (hits(address, IDX_ERROR_ENABLE)) readdata[7:0] <= errorEnable;
        if (hits(address, IDX_FRAME_ACCEPT)) readdata[4:0] <= frameAccept;
        if (hits(address, IDX_MODE_CONTROL)) readdata[1:0] <= modeControl;
        if (hits(address, IDX_PACKET_FLAGS)) readdata[7:0] <= packetFlags;
        if (hits(address, IDX_BAD_CRC_CNT))  readdata[7:0] <= badCrcCount;
        if (hits(address, IDX_DUP_CNT))      readdata[7:0] <= dupCount;
        if (hits(address, IDX_CNT_LIMIT))    readdata[7:0] <= countLimit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Plain read/write control registers.

  // Enables, accepted frame types, modes and the counter limit.
  always_ff @(posedge mclk) begin
    if (rst) begin
      eventEnable <= 8'h00;
      errorEnable <= 8'h00;
      frameAccept <= FRAME_ACCEPT_RESET;
      modeControl <= 2'b00;
      countLimit  <= CNT_LIMIT_RESET;
    end else if (busWrite) begin
      if (hits(address, IDX_EVENT_ENABLE)) eventEnable <= wByte & EV_ENABLE_MASK;
      if (hits(address, IDX_ERROR_ENABLE)) errorEnable <= wByte & ER_W1C_MASK;
      if (hits(address, IDX_FRAME_ACCEPT)) frameAccept <= wByte[4:0];
      if (hits(address, IDX_MODE_CONTROL)) modeControl <= wByte[1:0];
      if (hits(address, IDX_CNT_LIMIT))    countLimit  <= wByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Message classification.

  logic autoRetry;
  logic autoResp;
  logic startAccepted;
  logic expectedAck;
  logic dupDrop;
  logic protoError;
  logic msgDone;
  logic badCrc;

  assign autoRetry     = modeControl[MC_AUTO_RETRY];
  assign autoResp      = modeControl[MC_AUTO_RESP];
  assign startAccepted = rxIn.startSeen & (rxIn.startType < 3'd5) & frameAccept[rxIn.startType];
  assign expectedAck   = rxIn.msgGood & autoRetry & rxIn.goodCrcAwaited & rxIn.msgIsGoodCrc;
  assign dupDrop       = rxIn.msgGood & autoResp & rxIn.msgDuplicate & ~expectedAck;
  assign protoError    = rxIn.msgGood & autoRetry & rxIn.goodCrcAwaited
                         & ~rxIn.msgIsGoodCrc & ~rxIn.msgIsPing & ~dupDrop;
  assign msgDone       = rxIn.msgGood & ~expectedAck & ~dupDrop;
  assign badCrc        = rxIn.corrupt & rxIn.corruptCause[0];

  // A frame counts as accepted from its start framing until its end framing.
  always_ff @(posedge mclk) begin
    if (rst) begin
      frameOpen <= 1'b0;
    end else if (rxIn.startSeen) begin
      frameOpen <= startAccepted;
    end else if (rxIn.endSeen) begin
      frameOpen <= 1'b0;
    end
  end

  // Datapath commands; the reply request leaves with the done set, so status leads the reply.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxOut <= '0;
    end else begin
      rxOut.queueStore   <= msgDone;
      rxOut.dropPacket   <= expectedAck | dupDrop | rxIn.noBuffer;
      rxOut.replyRequest <= msgDone & autoResp;
      rxOut.retryAbort   <= protoError;
      rxOut.txAbortedSet <= protoError;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Debug counters: software clears one by writing its register.

  always_ff @(posedge mclk) begin
    if (rst) begin
      badCrcCount <= 8'h00;
      dupCount    <= 8'h00;
    end else begin
      if (busWrite && hits(address, IDX_BAD_CRC_CNT)) badCrcCount <= 8'h00;
      else if (badCrc) badCrcCount <= bump(badCrcCount);
      if (busWrite && hits(address, IDX_DUP_CNT)) dupCount <= 8'h00;
      else if (dupDrop) dupCount <= bump(dupCount);
    end
  end

  logic limitLevel;
  assign limitLevel = (countLimit != 8'h00)
                      & ((badCrcCount >= countLimit) | (dupCount >= countLimit));

  ////////////////////////////////////////////////////////////////////////////////
  // Line idle event detection.

  logic idleEvent;
  assign idleEvent = rxIn.clocksRunning & rxIn.lineIdle
                     & (~idleSeen | (eventEnable[EV_BUS_IDLE] & ~idleEnSeen));

  // Remembers the last idle level and the last enable level to find rising edges.
  always_ff @(posedge mclk) begin
    if (rst) begin
      idleSeen   <= 1'b1;
      idleEnSeen <= 1'b0;
    end else if (rxIn.clocksRunning) begin
      idleSeen   <= rxIn.lineIdle;
      idleEnSeen <= eventEnable[EV_BUS_IDLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status registers: a set in the clearing cycle wins over the clear.

  logic [7:0] eventSet;
  logic [7:0] errorSet;
  logic [7:0] eventClr;
  logic [7:0] errorClr;
  logic [7:0] flagSet;
  logic [7:0] flagClr;

  // Collects set and clear masks for each status register.
  always_comb begin
    eventSet = 8'h00;
    eventSet[EV_MSG_DONE]  = msgDone;
    eventSet[EV_START]     = startAccepted;
    eventSet[EV_END]       = rxIn.endSeen & frameOpen;
    eventSet[EV_HARD_RST]  = rxIn.hardReset;
    eventSet[EV_CABLE_RST] = rxIn.cableReset;
    eventSet[EV_BUS_IDLE]  = idleEvent;
    errorSet = 8'h00;
    errorSet[ER_DISCARD]   = expectedAck | dupDrop;
    errorSet[ER_PROTOCOL]  = protoError;
    errorSet[ER_OVERRUN]   = rxIn.noBuffer;
    errorSet[ER_CORRUPT]   = rxIn.corrupt;
    errorSet[ER_LIMIT]     = limitLevel;
    flagSet = 8'h00;
    flagSet[PS_BAD_CRC]    = rxIn.corrupt & rxIn.corruptCause[0];
    flagSet[PS_SYMBOL]     = rxIn.corrupt & rxIn.corruptCause[1];
    flagSet[PS_OVERSIZE]   = rxIn.corrupt & rxIn.corruptCause[2];
    flagSet[PS_UNEVEN]     = rxIn.corrupt & rxIn.corruptCause[3];
    flagSet[PS_FIFO_FULL]  = rxIn.noBuffer;
    eventClr = (busWrite && hits(address, IDX_EVENT_STATUS)) ? (wByte & EV_W1C_MASK) : 8'h00;
    errorClr = (busWrite && hits(address, IDX_ERROR_STATUS)) ? (wByte & ER_W1C_MASK) : 8'h00;
    flagClr  = (busWrite && hits(address, IDX_PACKET_FLAGS)) ? (wByte & PS_MASK) : 8'h00;
  end

  // Event status; bit 7 follows the FIFO level and bit 4 stays zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      eventStatus <= EV_STATUS_RESET;
    end else begin
      eventStatus <= (((eventStatus & ~eventClr) | eventSet) & EV_W1C_MASK)
                     | {rxIn.fifoNotEmpty, 7'h00};
    end
  end

  // Error status and packet status flags.
  always_ff @(posedge mclk) begin
    if (rst) begin
      errorStatus <= 8'h00;
      packetFlags <= 8'h00;
    end else begin
      errorStatus <= ((errorStatus & ~errorClr) | errorSet) & ER_W1C_MASK;
      packetFlags <= ((packetFlags & ~flagClr) | flagSet) & PS_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt output.

  // Any enabled status bit raises the interrupt line.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus & eventEnable) | |(errorStatus & errorEnable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  a_irq_needs_enable: assert property (@(posedge mclk) disable iff (rst)
    irq |-> $past(|(eventStatus & eventEnable) | |(errorStatus & errorEnable)))
    else $error("interrupt raised without an enabled status bit");

  a_fifo_bit_follow: assert property (@(posedge mclk) disable iff (rst)
    ##1 eventStatus[EV_FIFO_DATA] == $past(rxIn.fifoNotEmpty))
    else $error("fifo data bit does not follow fifo level");

  a_idle_needs_clock: assert property (@(posedge mclk) disable iff (rst)
    (!rxIn.clocksRunning && !eventStatus[EV_BUS_IDLE]) |=> !eventStatus[EV_BUS_IDLE])
    else $error("idle bit set while clocks stopped");

  a_end_needs_accept: assert property (@(posedge mclk) disable iff (rst)
    (rxIn.endSeen && !frameOpen && !eventStatus[EV_END]) |=> !eventStatus[EV_END])
    else $error("end bit set for a frame type not accepted");

  a_ack_drop_quiet: assert property (@(posedge mclk) disable iff (rst)
    expectedAck |=> !rxOut.queueStore && rxOut.dropPacket && errorStatus[ER_DISCARD])
    else $error("expected acknowledge not discarded");

  a_dup_drop_quiet: assert property (@(posedge mclk) disable iff (rst)
    dupDrop |=> !rxOut.queueStore && errorStatus[ER_DISCARD])
    else $error("duplicate packet not discarded");

  a_done_before_reply: assert property (@(posedge mclk) disable iff (rst)
    rxOut.replyRequest |-> eventStatus[EV_MSG_DONE])
    else $error("reply requested before done bit set");

  a_limit_sets_bit: assert property (@(posedge mclk) disable iff (rst)
    limitLevel |=> errorStatus[ER_LIMIT])
    else $error("limit bit not set at counter limit");

  a_proto_abort_store: assert property (@(posedge mclk) disable iff (rst)
    protoError |=> rxOut.retryAbort && rxOut.txAbortedSet && rxOut.queueStore
                   && eventStatus[EV_MSG_DONE] && errorStatus[ER_PROTOCOL])
    else $error("protocol error did not abort, store and flag");

  a_overrun_drop: assert property (@(posedge mclk) disable iff (rst)
    rxIn.noBuffer |=> rxOut.dropPacket && errorStatus[ER_OVERRUN] && packetFlags[PS_FIFO_FULL])
    else $error("overrun packet not dropped and flagged");

  a_set_beats_clear: assert property (@(posedge mclk) disable iff (rst)
    (errorSet[ER_CORRUPT] && errorClr[ER_CORRUPT]) |=> errorStatus[ER_CORRUPT])
    else $error("clear overrode a simultaneous set");

  a_bus_one_wait: assert property (@(posedge mclk) disable iff (rst)
    ($rose(read) || $rose(write)) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after exactly one wait cycle");

  c_proto_error: cover property (@(posedge mclk) disable iff (rst) protoError);
  c_dup_drop: cover property (@(posedge mclk) disable iff (rst) dupDrop);
  c_idle_on_enable: cover property (@(posedge mclk) disable iff (rst)
    rxIn.lineIdle && idleSeen && $rose(eventEnable[EV_BUS_IDLE]) ##1 eventStatus[EV_BUS_IDLE]);
  c_limit_event: cover property (@(posedge mclk) disable iff (rst) $rose(errorStatus[ER_LIMIT]));
  c_irq_rise: cover property (@(posedge mclk) disable iff (rst) $rose(irq));

endmodule

/* File: pd_rx_irq_pkg.sv */
// Package with register map, field positions, reset values and carrier types for the receive interrupt block.
package pd_rx_irq_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_EVENT_STATUS = 16'h1A82;
  localparam logic [15:0] IDX_ERROR_STATUS = 16'h1A83;
  localparam logic [15:0] IDX_EVENT_ENABLE = 16'h1A87;
  localparam logic [15:0] IDX_ERROR_ENABLE = 16'h1A88;
  localparam logic [15:0] IDX_FRAME_ACCEPT = 16'h1A90;
  localparam logic [15:0] IDX_MODE_CONTROL = 16'h1A91;
  localparam logic [15:0] IDX_PACKET_FLAGS = 16'h1A92;
  localparam logic [15:0] IDX_BAD_CRC_CNT  = 16'h1A93;
  localparam logic [15:0] IDX_DUP_CNT      = 16'h1A94;
  localparam logic [15:0] IDX_CNT_LIMIT    = 16'h1A95;

  localparam int ADDR_W = 18;

  // Receive event status bit positions.
  localparam int EV_MSG_DONE  = 0;
  localparam int EV_START     = 1;
  localparam int EV_END       = 2;
  localparam int EV_HARD_RST  = 3;
  localparam int EV_CABLE_RST = 5;
  localparam int EV_BUS_IDLE  = 6;
  localparam int EV_FIFO_DATA = 7;

  // Receive error status bit positions.
  localparam int ER_DISCARD  = 0;
  localparam int ER_PROTOCOL = 1;
  localparam int ER_OVERRUN  = 2;
  localparam int ER_CORRUPT  = 3;
  localparam int ER_LIMIT    = 7;

  // Packet status flag positions.
  localparam int PS_BAD_CRC   = 0;
  localparam int PS_OVERSIZE  = 3;
  localparam int PS_FIFO_FULL = 4;
  localparam int PS_SYMBOL    = 5;
  localparam int PS_UNEVEN    = 6;

  // Mode control bit positions.
  localparam int MC_AUTO_RETRY = 0;
  localparam int MC_AUTO_RESP  = 1;

  // Writable masks and reset values.
  localparam logic [7:0] EV_W1C_MASK     = 8'h6F;
  localparam logic [7:0] ER_W1C_MASK     = 8'h8F;
  localparam logic [7:0] PS_MASK         = 8'h79;
  localparam logic [7:0] EV_STATUS_RESET = 8'h40;
  localparam logic [7:0] EV_ENABLE_MASK  = 8'hEF;
  localparam logic [4:0] FRAME_ACCEPT_RESET = 5'h1F;
  localparam logic [7:0] CNT_LIMIT_RESET = 8'h0F;

  // Inputs from the receive datapath, all on the MAC clock.
  typedef struct packed {
    logic       fifoNotEmpty;   // Level: receive FIFO holds unread data.
    logic       lineIdle;       // Level: no activity on the delivery bus.
    logic       clocksRunning;  // Level: block clocks are running.
    logic       startSeen;      // Pulse: valid start-of-packet framing.
    logic [2:0] startType;      // Start-of-packet type index, 0 to 4.
    logic       endSeen;        // Pulse: valid end-of-packet framing.
    logic       cableReset;     // Pulse: cable reset signalling received.
    logic       hardReset;      // Pulse: hard reset signalling received.
    logic       msgGood;        // Pulse: message received with good CRC.
    logic       msgIsGoodCrc;   // Qualifier of msgGood: message is GoodCRC.
    logic       msgIsPing;      // Qualifier of msgGood: message is Ping.
    logic       msgDuplicate;   // Qualifier of msgGood: repeated message ID.
    logic       goodCrcAwaited; // Level: transmitter waits for GoodCRC.
    logic       corrupt;        // Pulse: corrupt packet arrived.
    logic [3:0] corruptCause;   // Bad CRC, symbol, oversize, uneven nibbles.
    logic       noBuffer;       // Pulse: packet arrived with no buffer space.
  } rx_in_t;

  // Commands to the receive and transmit datapaths, one-cycle pulses.
  typedef struct packed {
    logic queueStore;    // Store the message in the receive queue.
    logic dropPacket;    // Discard the packet.
    logic replyRequest;  // Send the automatic GoodCRC reply.
    logic retryAbort;    // Abandon the automatic retry sequence.
    logic txAbortedSet;  // Set the transmit-aborted status flag.
  } rx_out_t;

endpackage

/* File: sw_host_model.sv */
// Software-side Avalon-MM master that services receive interrupts.
`timescale 1ns/100ps
module sw_host_model (
  input  wire logic [31:0]                       readdata,
  input  wire logic                              waitrequest,
  input  wire logic                              mclk,
  output logic [pd_rx_irq_pkg::ADDR_W-1:0]       address,
  output logic                                   read,
  output logic                                   write,
  output logic [31:0]                            writedata,
  output logic [3:0]                             byteenable
);
  import pd_rx_irq_pkg::*;

  // The bus idles with no request at time zero.
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  // Holds one request until waitrequest is low at a rising edge, then releases it.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    address    <= {idx, 2'b00};
    read       <= ~wr;
    write      <= wr;
    writedata  <= {24'h000000, wd};
    byteenable <= 4'hF;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // On a counter-limit event both counters are read to learn which one caused it.
  task automatic readCounters(output logic [7:0] badCrc, output logic [7:0] dup);
    xfer(1'b0, IDX_BAD_CRC_CNT, 8'h00, badCrc);
    xfer(1'b0, IDX_DUP_CNT, 8'h00, dup);
  endtask
endmodule

/* File: tb_pd_rx_interrupt_status.sv */
// Self-checking testbench for the receive interrupt status block.
`timescale 1ns/100ps
module tb_pd_rx_interrupt_status;
  import pd_rx_irq_pkg::*;
  localparam logic [6:0] START_P = 7'h40;
  localparam logic [6:0] END_P   = 7'h20;
  localparam logic [6:0] CABLE_P = 7'h10;
  localparam logic [6:0] HARD_P  = 7'h08;
  localparam logic [6:0] MSG_P   = 7'h04;
  localparam logic [6:0] CORR_P  = 7'h02;
  localparam logic [6:0] NOBUF_P = 7'h01;
  logic                mclk;
  logic                rst;
  logic [ADDR_W-1:0]   address;
  logic                read;
  logic                write;
  logic [31:0]         writedata;
  logic [3:0]          byteenable;
  logic [31:0]         readdata;
  logic                waitrequest;
  rx_in_t              rxIn;
  rx_out_t             rxOut;
  logic                irq;
  int                  failCount;
  int                  totalChecks;
  rx_out_t             o;
  logic [7:0]          b;
  logic [7:0]          d;

  pd_rx_interrupt_status pd_rx_interrupt_status_i (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxIn(rxIn), .rxOut(rxOut), .irq(irq));
  sw_host_model sw_host_model_i (.readdata(readdata), .waitrequest(waitrequest), .mclk(mclk),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

  // The clock toggles every half period of 50 ns, for a period of 100 ns.
  always #50 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdChk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    sw_host_model_i.xfer(1'b0, idx, 8'h00, v);
    chk(what, exp, v);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] dat);
    logic [7:0] v;
    sw_host_model_i.xfer(1'b1, idx, dat, v);
  endtask
  // Pulses the chosen datapath events for one cycle and returns the commands of the cycle after.
  task automatic pulse(input logic [6:0] sel, input logic [3:0] q, output rx_out_t r);
    @(posedge mclk);
    {rxIn.startSeen, rxIn.endSeen, rxIn.cableReset, rxIn.hardReset, rxIn.msgGood, rxIn.corrupt, rxIn.noBuffer} <= sel;
    {rxIn.msgIsGoodCrc, rxIn.msgIsPing, rxIn.msgDuplicate} <= q[2:0];
    rxIn.corruptCause <= q;
    @(posedge mclk);
    {rxIn.startSeen, rxIn.endSeen, rxIn.cableReset, rxIn.hardReset, rxIn.msgGood, rxIn.corrupt, rxIn.noBuffer} <= 7'h00;
    @(posedge mclk);
    r = rxOut;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    rdChk("event status", IDX_EVENT_STATUS, 8'h40);
    rdChk("error status", IDX_ERROR_STATUS, 8'h00);
    rdChk("event enable", IDX_EVENT_ENABLE, 8'h00);
    rdChk("frame accept", IDX_FRAME_ACCEPT, 8'h1F);
    rdChk("unmapped", 16'h1AA0, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic testEvents();
    logic [6:0] sel [5];
    int pos [5];
    sel = '{START_P, END_P, CABLE_P, HARD_P, MSG_P};
    pos = '{EV_START, EV_END, EV_CABLE_RST, EV_HARD_RST, EV_MSG_DONE};
    for (int i = 0; i < 5; i++) begin
      pulse(sel[i], 4'h0, o);
      rdChk("event set", IDX_EVENT_STATUS, 8'h40 | (8'h01 << pos[i]));
      wr(IDX_EVENT_STATUS, 8'h01 << pos[i]);
      rdChk("event cleared", IDX_EVENT_STATUS, 8'h40);
    end
    wr(IDX_EVENT_STATUS, 8'hFF);
    rdChk("reserved bit", IDX_EVENT_STATUS, 8'h00);
  endtask
  task automatic testFifo();
    @(posedge mclk) rxIn.fifoNotEmpty <= 1'b1;
    rdChk("fifo bit", IDX_EVENT_STATUS, 8'h80);
    wr(IDX_EVENT_STATUS, 8'h80);
    rdChk("fifo read only", IDX_EVENT_STATUS, 8'h80);
    @(posedge mclk) rxIn.fifoNotEmpty <= 1'b0;
    rdChk("fifo drained", IDX_EVENT_STATUS, 8'h00);
  endtask
  task automatic testIrq();
    pulse(HARD_P, 4'h0, o);
    rdChk("masked status", IDX_EVENT_STATUS, 8'h08);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(IDX_EVENT_ENABLE, 8'h08);
    rdChk("event enable", IDX_EVENT_ENABLE, 8'h08);
    chk("irq enabled", 8'h01, {7'h00, irq});
    wr(IDX_EVENT_STATUS, 8'h08);
    rdChk("cleared", IDX_EVENT_STATUS, 8'h00);
    chk("irq cleared", 8'h00, {7'h00, irq});
    wr(IDX_EVENT_ENABLE, 8'h00);
  endtask
  task automatic testIdle();
    @(posedge mclk) rxIn.clocksRunning <= 1'b0;
    @(posedge mclk) rxIn.lineIdle <= 1'b1;
    rdChk("idle clocks off", IDX_EVENT_STATUS, 8'h00);
    @(posedge mclk) rxIn.lineIdle <= 1'b0;
    @(posedge mclk) rxIn.clocksRunning <= 1'b1;
    @(posedge mclk) rxIn.lineIdle <= 1'b1;
    rdChk("went idle", IDX_EVENT_STATUS, 8'h40);
    wr(IDX_EVENT_STATUS, 8'h40);
    rdChk("idle cleared", IDX_EVENT_STATUS, 8'h00);
    wr(IDX_EVENT_ENABLE, 8'h40);
    rdChk("idle on enable", IDX_EVENT_STATUS, 8'h40);
    chk("irq idle", 8'h01, {7'h00, irq});
    wr(IDX_EVENT_ENABLE, 8'h00);
    wr(IDX_EVENT_STATUS, 8'h40);
    @(posedge mclk) rxIn.lineIdle <= 1'b0;
  endtask
  task automatic testAutoResp();
    wr(IDX_MODE_CONTROL, 8'h02);
    pulse(MSG_P, 4'h1, o);
    chk("dup drop", 8'h01, {7'h00, o.dropPacket});
    rdChk("dup no done", IDX_EVENT_STATUS, 8'h00);
    rdChk("dup discard", IDX_ERROR_STATUS, 8'h01);
    rdChk("dup count", IDX_DUP_CNT, 8'h01);
    wr(IDX_DUP_CNT, 8'h00);
    wr(IDX_ERROR_STATUS, 8'h01);
    pulse(MSG_P, 4'h0, o);
    chk("reply and store", 8'h03, {6'h00, o.replyRequest, o.queueStore});
    rdChk("done before reply", IDX_EVENT_STATUS, 8'h01);
    wr(IDX_EVENT_STATUS, 8'h01);
  endtask
  task automatic testAutoRetry();
    wr(IDX_MODE_CONTROL, 8'h01);
    @(posedge mclk) rxIn.goodCrcAwaited <= 1'b1;
    pulse(MSG_P, 4'h4, o);
    rdChk("goodcrc no done", IDX_EVENT_STATUS, 8'h00);
    rdChk("goodcrc discard", IDX_ERROR_STATUS, 8'h01);
    wr(IDX_ERROR_STATUS, 8'h01);
    pulse(MSG_P, 4'h0, o);
    chk("abort cmds", 8'h07, {5'h00, o.queueStore, o.retryAbort, o.txAbortedSet});
    rdChk("protocol error", IDX_ERROR_STATUS, 8'h02);
    rdChk("protocol done", IDX_EVENT_STATUS, 8'h01);
    wr(IDX_ERROR_STATUS, 8'h02);
    pulse(MSG_P, 4'h2, o);
    rdChk("ping no error", IDX_ERROR_STATUS, 8'h00);
    wr(IDX_EVENT_STATUS, 8'h01);
    @(posedge mclk) rxIn.goodCrcAwaited <= 1'b0;
    wr(IDX_MODE_CONTROL, 8'h00);
  endtask
  task automatic testErrors();
    pulse(CORR_P, 4'h2, o);
    wr(IDX_ERROR_ENABLE, 8'h08);
    rdChk("corrupt", IDX_ERROR_STATUS, 8'h08);
    rdChk("symbol cause", IDX_PACKET_FLAGS, 8'h20);
    chk("irq error", 8'h01, {7'h00, irq});
    wr(IDX_ERROR_ENABLE, 8'h00);
    pulse(NOBUF_P, 4'h0, o);
    chk("overrun drop", 8'h01, {7'h00, o.dropPacket});
    rdChk("overrun", IDX_ERROR_STATUS, 8'h0C);
    rdChk("fifo full flag", IDX_PACKET_FLAGS, 8'h30);
    wr(IDX_ERROR_STATUS, 8'h0C);
    wr(IDX_PACKET_FLAGS, 8'hFF);
  endtask
  task automatic testLimit();
    wr(IDX_CNT_LIMIT, 8'h01);
    pulse(CORR_P, 4'h1, o);
    rdChk("bad crc limit", IDX_ERROR_STATUS, 8'h88);
    sw_host_model_i.readCounters(b, d);
    chk("bad crc count", 8'h01, b);
    chk("dup count", 8'h00, d);
    wr(IDX_ERROR_STATUS, 8'h88);
    rdChk("limit persists", IDX_ERROR_STATUS, 8'h80);
    wr(IDX_BAD_CRC_CNT, 8'h00);
    wr(IDX_ERROR_STATUS, 8'h80);
    rdChk("limit cleared", IDX_ERROR_STATUS, 8'h00);
    wr(IDX_MODE_CONTROL, 8'h02);
    pulse(MSG_P, 4'h1, o);
    rdChk("dup limit", IDX_ERROR_STATUS, 8'h81);
    wr(IDX_DUP_CNT, 8'h00);
    wr(IDX_ERROR_STATUS, 8'h81);
    wr(IDX_PACKET_FLAGS, 8'hFF);
    wr(IDX_MODE_CONTROL, 8'h00);
    wr(IDX_CNT_LIMIT, 8'h0F);
  endtask
  task automatic testAccept();
    wr(IDX_FRAME_ACCEPT, 8'h1E);
    pulse(START_P, 4'h0, o);
    pulse(END_P, 4'h0, o);
    rdChk("type refused", IDX_EVENT_STATUS, 8'h00);
    @(posedge mclk) rxIn.startType <= 3'd1;
    pulse(START_P, 4'h0, o);
    pulse(END_P, 4'h0, o);
    rdChk("type accepted", IDX_EVENT_STATUS, 8'h06);
    wr(IDX_EVENT_STATUS, 8'h06);
    wr(IDX_FRAME_ACCEPT, 8'h1F);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic endSim();
    if (failCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    rxIn = '0;
    rxIn.clocksRunning = 1'b1;
    failCount = 0;
    totalChecks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testEvents();
    testFifo();
    testIrq();
    testIdle();
    testAutoResp();
    testAutoRetry();
    testErrors();
    testLimit();
    testAccept();
    endSim();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #2000000;
    failCount++;
    endSim();
  end
endmodule
